/* core/uum_pkg.sv */
// Purpose: Shared constants for the channel register map and line status logic
// Assumes: Eight-bit host bus, three-bit register address, 16-deep FIFOs
// Notes: Trigger levels and reset bytes are plain defaults
package uum_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int LEVEL_W = 5;

	// Register addresses
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_ENABLE = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SPR = 3'h7;

	// Field positions
	localparam int LCR_DIV_BIT = 7;
	localparam int EFR_ENH_BIT = 4;
	localparam int FCR_EN_BIT = 0;
	localparam int FCR_RXRST_BIT = 1;
	localparam int FCR_TXRST_BIT = 2;
	localparam int IER_RX_BIT = 0;
	localparam int IER_TX_BIT = 1;
	localparam int IER_LS_BIT = 2;
	localparam int IER_MS_BIT = 3;
	localparam int IER_SLEEP_BIT = 4;
	localparam int IER_XOFF_BIT = 5;
	localparam int IER_RTS_BIT = 6;
	localparam int IER_CTS_BIT = 7;

	// Enhanced-access key and masks of the gated bits
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
	localparam logic [7:0] IER_STD_MASK = 8'h0F;
	localparam logic [7:0] MCR_STD_MASK = 8'h1F;
	localparam logic [7:0] FCR_STD_MASK = 8'hCF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Interrupt source codes, bits 5:0
	localparam logic [5:0] ISR_LSR = 6'h06;
	localparam logic [5:0] ISR_TIMEOUT = 6'h0C;
	localparam logic [5:0] ISR_RXRDY = 6'h04;
	localparam logic [5:0] ISR_TXRDY = 6'h02;
	localparam logic [5:0] ISR_MSR = 6'h00;
	localparam logic [5:0] ISR_XOFF = 6'h10;
	localparam logic [5:0] ISR_FLOW = 6'h20;
	localparam logic [5:0] ISR_NONE = 6'h01;

	// Receive trigger levels selected by queue_control bits 7:6
	localparam logic [4:0] TRIG_LVL0 = 5'h01;
	localparam logic [4:0] TRIG_LVL1 = 5'h04;
	localparam logic [4:0] TRIG_LVL2 = 5'h08;
	localparam logic [4:0] TRIG_LVL3 = 5'h0E;

	// Idle value of synchronised pins: select and strobes high
	localparam logic [13:0] BUS_IDLE = 14'h3800;

	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		case (sel)
			2'h0: trig_level = TRIG_LVL0;
			2'h1: trig_level = TRIG_LVL1;
			2'h2: trig_level = TRIG_LVL2;
			default: trig_level = TRIG_LVL3;
		endcase
	endfunction

	function automatic logic [7:0] enh_mask(input logic [7:0] std, input logic en);
		enh_mask = en ? 8'hFF : std;
	endfunction

endpackage

/* core/uum_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous host bus pins
// Assumes: Bits are sampled independently; bus cycles are slow
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module uum_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // uum_sync
`default_nettype wire

/* core/uum_err_tally.sv */
// Purpose: Counts characters in the receive FIFO that carry an error
// Assumes: Push and pop come from the FIFO on the same clock
// Notes: Clear is a FIFO reset and wins over push and pop
`timescale 1ns/1ps
`default_nettype none
module uum_err_tally
	import uum_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	input  wire logic push_i,
	input  wire logic push_err_i,
	input  wire logic pop_i,
	input  wire logic pop_err_i,
	input  wire logic clear_i,
	output logic      any_err_o
);
	logic [LEVEL_W-1:0] cnt_q;
	logic [LEVEL_W-1:0] cnt_d;
	wire                inc = push_i & push_err_i;
	wire                dec = pop_i & pop_err_i & (cnt_q != '0);

	assign cnt_d = clear_i ? '0 :
		(inc & ~dec) ? LEVEL_W'(cnt_q + 1'b1) :
		(dec & ~inc) ? LEVEL_W'(cnt_q - 1'b1) : cnt_q;
	assign any_err_o = cnt_q != '0;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule // uum_err_tally
`default_nettype wire

/* core/uum_regs.sv */
// Purpose: Register map, interrupt masking and line status of one channel
// Assumes: Host bus pins are asynchronous; FIFO and shifters are same-clock logic
// Notes: Bus cycle side effects take place when the strobe ends
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Enhanced bits of enable, status, queue and modem control work only with feature bit 4.
// - Enable register masks rx-ready, tx-empty, line and modem sources; status reports them.
// - FIFO and rx enabled: interrupt while receive level is at or above trigger.
// - Status bit 2 shows receive level while trigger reached, clear below it.
// - Line status bit 0 set once a character enters FIFO, clear when empty.
// - Receive and transmit conditions sit in separate line status bits.
// - Line status bit 1 set on receive overrun.
// - Line status bits 2 to 4 give errors of the head character.
// - Line status bit 5 high while transmit FIFO or holding register empty.
// - Line status bit 6 high only when transmit FIFO and shift register empty.
// - Line status bit 7 set while any stored character carries an error.
// - Enhanced bits ignored and read zero unless feature bit 4 is one.
// - Three-bit address decode; respond only while channel select is low.
// - Status read returns highest-priority pending source; others wait.
module uum_regs
	import uum_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic [2:0]  bus_addr_i,
	input  wire logic        chan_select_n_i,
	input  wire logic        read_n_i,
	input  wire logic        write_n_i,
	input  wire logic [7:0]  bus_data_i,
	output logic      [7:0]  bus_data_o,
	output logic             bus_data_oe_o,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic [4:0]  rx_count_i,
	input  wire logic        rx_push_i,
	input  wire logic        rx_push_err_i,
	input  wire logic [2:0]  rx_head_err_i,
	input  wire logic        rx_overrun_i,
	input  wire logic        rx_timeout_i,
	input  wire logic        tx_fifo_empty_i,
	input  wire logic        tx_shift_empty_i,
	input  wire logic [7:0]  modem_status_i,
	input  wire logic        xoff_seen_i,
	input  wire logic        flow_pin_rise_i,
	output logic             irq_o,
	output logic             rx_read_o,
	output logic             tx_write_o,
	output logic      [7:0]  tx_data_o,
	output logic             modem_read_o,
	output logic             rx_fifo_reset_o,
	output logic             tx_fifo_reset_o,
	output logic      [7:0]  queue_control_o,
	output logic      [7:0]  interrupt_enable_o,
	output logic      [7:0]  line_format_o,
	output logic      [7:0]  modem_output_o,
	output logic      [7:0]  divisor_low_o,
	output logic      [7:0]  divisor_high_o,
	output logic      [7:0]  enhanced_feature_o,
	output logic      [7:0]  resume_char_one_o,
	output logic      [7:0]  resume_char_two_o,
	output logic      [7:0]  pause_char_one_o,
	output logic      [7:0]  pause_char_two_o
);
	// Pin synchronisation
	logic [13:0] pins_s;
	logic        rd_act_q;
	logic        wr_act_q;
	logic [2:0]  addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  spr_q;
	logic        overrun_q;
	logic        tx_int_q;
	logic        tx_empty_q;
	logic        xoff_int_q;
	logic        flow_int_q;
	logic        err_glob;

	uum_sync #(.W(14), .RESET_VAL(BUS_IDLE)) u_sync (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   ({chan_select_n_i, read_n_i, write_n_i, bus_addr_i, bus_data_i}),
		.sync_o    (pins_s)
	);

	wire       s_cs_n  = pins_s[13];
	wire       s_rd_n  = pins_s[12];
	wire       s_wr_n  = pins_s[11];
	wire [2:0] s_addr  = pins_s[10:8];
	wire [7:0] s_wdata = pins_s[7:0];
	wire       rd_act  = ~s_cs_n & ~s_rd_n;
	wire       wr_act  = ~s_cs_n & ~s_wr_n;
	// Latched address and data of the last active cycle drive the commit
	wire       rd_end  = rd_act_q & ~rd_act;
	wire       wr_end  = wr_act_q & ~wr_act;

	// Map steering
	wire enh_map  = line_format_o == LCR_ENH_KEY;
	wire div_map  = line_format_o[LCR_DIV_BIT];
	wire enh_on   = enhanced_feature_o[EFR_ENH_BIT];
	wire fifo_en  = queue_control_o[FCR_EN_BIT];

	wire wr_data  = wr_end & (addr_q == ADDR_DATA) & ~div_map;
	wire wr_ier   = wr_end & (addr_q == ADDR_ENABLE) & ~div_map;
	wire wr_fcr   = wr_end & (addr_q == ADDR_ISR) & ~enh_map;
	wire wr_efr   = wr_end & (addr_q == ADDR_ISR) & enh_map;
	wire rd_rhr   = rd_end & (addr_q == ADDR_DATA) & ~div_map;
	wire rd_isr   = rd_end & (addr_q == ADDR_ISR) & ~enh_map;
	wire rd_lsr   = rd_end & (addr_q == ADDR_LSR) & ~enh_map;
	wire rd_msr   = rd_end & (addr_q == ADDR_MSR) & ~enh_map;
	wire rx_rst   = wr_fcr & wdata_q[FCR_EN_BIT] & wdata_q[FCR_RXRST_BIT];
	wire tx_rst   = wr_fcr & wdata_q[FCR_EN_BIT] & wdata_q[FCR_TXRST_BIT];

	// Line status
	wire       rx_has  = rx_count_i != '0;
	wire [2:0] head_er = rx_has ? rx_head_err_i : 3'h0;
	wire [7:0] lsr_byte = {err_glob & rx_has,
		tx_fifo_empty_i & tx_shift_empty_i,
		tx_fifo_empty_i,
		head_er, overrun_q, rx_has};

	uum_err_tally u_tally (
		.mclk_i     (mclk_i),
		.reset_n_i  (reset_n_i),
		.push_i     (rx_push_i),
		.push_err_i (rx_push_err_i),
		.pop_i      (rd_rhr),
		.pop_err_i  (|head_er),
		.clear_i    (rx_rst),
		.any_err_o  (err_glob)
	);

	// Interrupt sources and priority
	wire [7:0] interrupt_enable_reg     = interrupt_enable_o;
	wire [4:0] trig    = trig_level(queue_control_o[7:6]);
	wire       rx_lvl  = fifo_en ? (rx_count_i >= trig) : rx_has;
	wire       p_ls    = interrupt_enable_reg[IER_LS_BIT] & (overrun_q | (|head_er));
	wire       p_to    = interrupt_enable_reg[IER_RX_BIT] & fifo_en & rx_timeout_i & rx_has;
	wire       p_rx    = interrupt_enable_reg[IER_RX_BIT] & rx_lvl;
	wire       p_tx    = interrupt_enable_reg[IER_TX_BIT] & tx_int_q;
	wire       p_ms    = interrupt_enable_reg[IER_MS_BIT] & (|modem_status_i[3:0]);
	wire       p_xo    = enh_on & interrupt_enable_reg[IER_XOFF_BIT] & xoff_int_q;
	wire       p_fl    = enh_on & (interrupt_enable_reg[IER_RTS_BIT] | interrupt_enable_reg[IER_CTS_BIT]) & flow_int_q;
	wire [5:0] isr_code = p_ls ? ISR_LSR :
		p_to ? ISR_TIMEOUT :
		p_rx ? ISR_RXRDY :
		p_tx ? ISR_TXRDY :
		p_ms ? ISR_MSR :
		p_xo ? ISR_XOFF :
		p_fl ? ISR_FLOW : ISR_NONE;
	wire [7:0] isr_byte = {fifo_en, fifo_en, isr_code};

	// Transmit-ready arms on an empty edge or when enabled while empty
	wire tx_arm = (tx_fifo_empty_i & ~tx_empty_q) |
		(wr_ier & wdata_q[IER_TX_BIT] & ~interrupt_enable_reg[IER_TX_BIT] & tx_fifo_empty_i);
	wire tx_clr = wr_data | (rd_isr & isr_code == ISR_TXRDY);
	wire xo_clr = rd_isr & isr_code == ISR_XOFF;

	// Read mux, shared addresses chosen by the divisor bit (addresses 0 and 1) or the map key (2 and 4 to 7)
	wire [7:0] rd_mux =
		(s_addr == ADDR_DATA)   ? (div_map ? divisor_low_o : rx_data_i) :
		(s_addr == ADDR_ENABLE) ? (div_map ? divisor_high_o : interrupt_enable_reg) :
		(s_addr == ADDR_ISR)    ? (enh_map ? enhanced_feature_o : isr_byte) :
		(s_addr == ADDR_LCR)    ? line_format_o :
		(s_addr == ADDR_MCR)    ? (enh_map ? resume_char_one_o : modem_output_o) :
		(s_addr == ADDR_LSR)    ? (enh_map ? resume_char_two_o : lsr_byte) :
		(s_addr == ADDR_MSR)    ? (enh_map ? pause_char_one_o : modem_status_i) :
		(enh_map ? pause_char_two_o : spr_q);

	// Write masks; enhanced bits cannot be written while disabled
	wire [7:0] ier_mask = enh_mask(IER_STD_MASK, enh_on);
	wire [7:0] mcr_mask = enh_mask(MCR_STD_MASK, enh_on);
	wire [7:0] fcr_mask = enh_mask(FCR_STD_MASK, enh_on);
	wire       enh_drop = wr_efr & ~wdata_q[EFR_ENH_BIT];

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
			addr_q   <= 3'h0;
			wdata_q  <= RESET_BYTE;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
			addr_q   <= s_addr;
			wdata_q  <= s_wdata;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_data_o    <= RESET_BYTE;
			bus_data_oe_o <= 1'b0;
			irq_o         <= 1'b0;
		end else begin
			bus_data_o    <= rd_act ? rd_mux : RESET_BYTE;
			bus_data_oe_o <= rd_act;
			irq_o         <= isr_code != ISR_NONE;
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overrun_q  <= 1'b0;
			tx_int_q   <= 1'b0;
			tx_empty_q <= 1'b1;
			xoff_int_q <= 1'b0;
			flow_int_q <= 1'b0;
		end else begin
			overrun_q  <= rx_overrun_i | (overrun_q & ~rd_lsr);
			tx_int_q   <= tx_arm | (tx_int_q & ~tx_clr);
			tx_empty_q <= tx_fifo_empty_i;
			xoff_int_q <= xoff_seen_i | (xoff_int_q & ~xo_clr);
			flow_int_q <= flow_pin_rise_i | (flow_int_q & ~rd_msr);
		end
	end

	// Side-effect pulses
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_read_o       <= 1'b0;
			tx_write_o      <= 1'b0;
			tx_data_o       <= RESET_BYTE;
			modem_read_o    <= 1'b0;
			rx_fifo_reset_o <= 1'b0;
			tx_fifo_reset_o <= 1'b0;
		end else begin
			rx_read_o       <= rd_rhr;
			tx_write_o      <= wr_data;
			tx_data_o       <= wr_data ? wdata_q : tx_data_o;
			modem_read_o    <= rd_msr;
			rx_fifo_reset_o <= rx_rst;
			tx_fifo_reset_o <= tx_rst;
		end
	end

	// Stored registers
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			queue_control_o    <= RESET_BYTE;
			interrupt_enable_o <= RESET_BYTE;
			line_format_o      <= RESET_BYTE;
			modem_output_o     <= RESET_BYTE;
			divisor_low_o      <= RESET_BYTE;
			divisor_high_o     <= RESET_BYTE;
			enhanced_feature_o <= RESET_BYTE;
			resume_char_one_o  <= RESET_BYTE;
			resume_char_two_o  <= RESET_BYTE;
			pause_char_one_o   <= RESET_BYTE;
			pause_char_two_o   <= RESET_BYTE;
			spr_q              <= RESET_BYTE;
		end else if (enh_drop) begin
			// Dropping the feature bit clears every gated bit at once
			enhanced_feature_o <= wdata_q;
			interrupt_enable_o <= interrupt_enable_o & IER_STD_MASK;
			modem_output_o     <= modem_output_o & MCR_STD_MASK;
			queue_control_o    <= queue_control_o & FCR_STD_MASK;
		end else if (wr_end) begin
			case (addr_q)
				ADDR_DATA: begin
					if (div_map)
						divisor_low_o <= wdata_q;
				end
				ADDR_ENABLE: begin
					if (div_map)
						divisor_high_o <= wdata_q;
					else
						interrupt_enable_o <= wdata_q & ier_mask;
				end
				ADDR_ISR: begin
					if (enh_map)
						enhanced_feature_o <= wdata_q;
					else if (wdata_q[FCR_EN_BIT])
						queue_control_o <= wdata_q & fcr_mask & 8'hF9;
					else
						queue_control_o <= queue_control_o & 8'hFE;
				end
				ADDR_LCR: line_format_o <= wdata_q;
				ADDR_MCR: begin
					if (enh_map)
						resume_char_one_o <= wdata_q;
					else
						modem_output_o <= wdata_q & mcr_mask;
				end
				ADDR_LSR: begin
					if (enh_map)
						resume_char_two_o <= wdata_q;
				end
				ADDR_MSR: begin
					if (enh_map)
						pause_char_one_o <= wdata_q;
				end
				default: begin
					if (enh_map)
						pause_char_two_o <= wdata_q;
					else
						spr_q <= wdata_q;
				end
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	chk_enh_bits_gated: assert property (
		!enh_on |-> (interrupt_enable_o[7:4] == 4'h0 && modem_output_o[7:5] == 3'h0))
		else $error("enhanced bits live while feature bit clear");
	chk_mask_quiet: assert property (
		(interrupt_enable_reg[3:0] == 4'h0 && !enh_on) |=> !irq_o)
		else $error("interrupt raised with all sources masked");
	chk_rx_trigger: assert property (
		(fifo_en && interrupt_enable_reg[IER_RX_BIT] && rx_count_i >= trig) |=> irq_o)
		else $error("receive trigger reached without interrupt");
	chk_rx_level_code: assert property (
		(fifo_en && rx_count_i < trig) |-> isr_code != ISR_RXRDY)
		else $error("receive level shown below trigger");
	chk_data_ready: assert property (
		(rd_act && s_addr == ADDR_LSR && !enh_map) |=> bus_data_o[0] == $past(rx_has))
		else $error("data ready bit disagrees with FIFO level");
	chk_overrun_held: assert property (
		(rx_overrun_i || (overrun_q && !rd_lsr)) |=> overrun_q)
		else $error("overrun flag lost before line status read");
	chk_both_empty: assert property (
		lsr_byte[6] |-> (lsr_byte[5] && tx_shift_empty_i))
		else $error("shift-empty bit without both empty");
	chk_error_global: assert property (
		(rx_push_i && rx_push_err_i && !rx_rst) |=> err_glob)
		else $error("stored error not flagged");
	chk_enh_readback: assert property (
		(rd_act && enh_map && s_addr == ADDR_ISR) |=> bus_data_o == $past(enhanced_feature_o))
		else $error("feature register not mapped under key");
	chk_fifo_bits: assert property (
		(rd_act && !enh_map && s_addr == ADDR_ISR) |=> bus_data_o[7:6] == {2{$past(fifo_en)}})
		else $error("FIFO enable bits wrong in status");
	chk_chan_select: assert property (
		s_cs_n |=> !bus_data_oe_o ##0 (bus_data_o == RESET_BYTE))
		else $error("driving bus while deselected");
	chk_line_first: assert property (
		p_ls |=> $past(isr_code) == ISR_LSR ##0 irq_o)
		else $error("line status not top priority");

endmodule // uum_regs
`default_nettype wire

/* test/uum_host.sv */
// Purpose: Host processor model on the eight-bit parallel register bus
// Assumes: Write strobe held low six clocks, read strobe until output enable (at most eight); high at least six clocks
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module uum_host (
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rdata_oe_i,
	output logic      [2:0] addr_o,
	output logic            sel_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [7:0] wdata_o
);
	initial begin
		addr_o = 3'h0;
		sel_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wdata_o = 8'h00;
	end

	// Address and data held through the whole strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		sel_n_o <= ~sel;
		wr_n_o <= 1'b0;
		repeat (6) @(posedge mclk_i);
		sel_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
		wdata_o <= ~d;
		repeat (3) @(posedge mclk_i);
	endtask

	// Read holds the strobe until output enable, at most eight clocks, then samples the data
	task automatic rd(input logic [2:0] a, input logic sel, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		@(posedge mclk_i);
		addr_o <= a;
		sel_n_o <= ~sel;
		rd_n_o <= 1'b0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (rdata_oe_i !== 1'b1 && n < 8);
		ok = (rdata_oe_i === 1'b1);
		d = rdata_i;
		sel_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		repeat (6) @(posedge mclk_i);
	endtask
endmodule // uum_host
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the channel register map
// Assumes: Receive FIFO and transmitter are stood in for by the bench
// Notes: Timeout and flow inputs are held quiet
`timescale 1ns/1ps
`default_nettype none
module tb;
	import uum_pkg::*;
	logic       mclk_i, reset_n_i;
	logic [2:0] addr, head_err;
	logic       sel_n, rd_n, wr_n, oe, irq, push, push_err, ovr, tx_e, sh_e, xoff;
	logic       txw, rxr, rxrst, txrst, msrd;
	logic [7:0] wdata, rdata, ien, dl, dh, resume_char_one, qc, rxd, modem_input_status, txd, modem_output_control, enhanced_feature_control;
	logic [4:0] count;
	int         n_fail, comparisons, cycles;
	int         n_txw, n_rxr, n_rxrst, n_txrst, n_msrd;

	uum_host host_u (.mclk_i(mclk_i), .rdata_i(rdata), .rdata_oe_i(oe), .addr_o(addr),
		.sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(wdata));

	uum_regs dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_addr_i(addr),
		.chan_select_n_i(sel_n), .read_n_i(rd_n), .write_n_i(wr_n), .bus_data_i(wdata),
		.bus_data_o(rdata), .bus_data_oe_o(oe), .rx_data_i(rxd), .rx_count_i(count),
		.rx_push_i(push), .rx_push_err_i(push_err), .rx_head_err_i(head_err),
		.rx_overrun_i(ovr), .rx_timeout_i(1'b0), .tx_fifo_empty_i(tx_e),
		.tx_shift_empty_i(sh_e), .modem_status_i(modem_input_status), .xoff_seen_i(xoff),
		.flow_pin_rise_i(1'b0), .irq_o(irq), .rx_read_o(rxr), .tx_write_o(txw), .tx_data_o(txd),
		.modem_read_o(msrd), .rx_fifo_reset_o(rxrst), .tx_fifo_reset_o(txrst), .queue_control_o(qc),
		.interrupt_enable_o(ien), .line_format_o(), .modem_output_o(modem_output_control),
		.divisor_low_o(dl), .divisor_high_o(dh), .enhanced_feature_o(enhanced_feature_control),
		.resume_char_one_o(resume_char_one), .resume_char_two_o(), .pause_char_one_o(),
		.pause_char_two_o());

	always #10 mclk_i = ~mclk_i;

	// Pulses stand one cycle, so they are tallied as they pass
	always @(posedge mclk_i) begin
		if (rxr === 1'b1)
			n_rxr <= n_rxr + 1;
		if (txw === 1'b1)
			n_txw <= n_txw + 1;
		if (msrd === 1'b1)
			n_msrd <= n_msrd + 1;
		if (rxrst === 1'b1)
			n_rxrst <= n_rxrst + 1;
		if (txrst === 1'b1)
			n_txrst <= n_txrst + 1;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host_u.rd(a, 1'b1, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic t_select();
		logic [7:0] d;
		logic       ok;
		host_u.wr(ADDR_SPR, 8'hA5, 1'b1);
		host_u.wr(ADDR_SPR, 8'h3C, 1'b0);
		rd_chk(ADDR_SPR, 8'hA5);
		host_u.rd(ADDR_SPR, 1'b0, d, ok);
		chk({7'h00, ok}, 8'h00);
	endtask

	task automatic t_enhanced();
		host_u.wr(ADDR_ENABLE, 8'hFF, 1'b1);
		rd_chk(ADDR_ENABLE, 8'h0F);
		chk(ien, 8'h0F);
		host_u.wr(ADDR_LCR, 8'hBF, 1'b1);
		host_u.wr(ADDR_ISR, 8'h10, 1'b1);
		rd_chk(ADDR_ISR, 8'h10);
		host_u.wr(ADDR_MCR, 8'h5A, 1'b1);
		chk(resume_char_one, 8'h5A);
		host_u.wr(ADDR_LCR, 8'h03, 1'b1);
		host_u.wr(ADDR_ENABLE, 8'hFF, 1'b1);
		rd_chk(ADDR_ENABLE, 8'hFF);
		host_u.wr(ADDR_ENABLE, 8'h00, 1'b1);
		host_u.wr(ADDR_LCR, 8'h80, 1'b1);
		host_u.wr(ADDR_DATA, 8'h12, 1'b1);
		host_u.wr(ADDR_ENABLE, 8'h34, 1'b1);
		rd_chk(ADDR_ENABLE, 8'h34);
		chk(dl, 8'h12);
		chk(dh, 8'h34);
		host_u.wr(ADDR_LCR, 8'h03, 1'b1);
	endtask

	task automatic t_rx_trigger();
		host_u.wr(ADDR_ISR, 8'h41, 1'b1);
		chk(qc, 8'h41);
		host_u.wr(ADDR_ENABLE, 8'h01, 1'b1);
		count <= 5'h03;
		repeat (4) @(posedge mclk_i);
		chk({7'h00, irq}, 8'h00);
		rd_chk(ADDR_ISR, 8'hC1);
		count <= TRIG_LVL1;
		repeat (4) @(posedge mclk_i);
		chk({7'h00, irq}, 8'h01);
		rd_chk(ADDR_ISR, 8'hC4);
		count <= 5'h03;
		repeat (4) @(posedge mclk_i);
		chk({7'h00, irq}, 8'h00);
		rd_chk(ADDR_ISR, 8'hC1);
		// Masked source stays quiet above trigger
		host_u.wr(ADDR_ENABLE, 8'h00, 1'b1);
		count <= TRIG_LVL2;
		repeat (4) @(posedge mclk_i);
		chk({7'h00, irq}, 8'h00);
	endtask

	// FIFOs on and all sources masked: the polled mode
	task automatic t_line_status();
		count <= 5'h02;
		head_err <= 3'b010;
		tx_e <= 1'b1;
		rd_chk(ADDR_LSR, 8'h29);
		sh_e <= 1'b1;
		rd_chk(ADDR_LSR, 8'h69);
		@(posedge mclk_i);
		ovr <= 1'b1;
		@(posedge mclk_i);
		ovr <= 1'b0;
		rd_chk(ADDR_LSR, 8'h6B);
		rd_chk(ADDR_LSR, 8'h69);
		push <= 1'b1;
		push_err <= 1'b1;
		@(posedge mclk_i);
		push <= 1'b0;
		push_err <= 1'b0;
		rd_chk(ADDR_LSR, 8'hE9);
		count <= 5'h00;
		head_err <= 3'b000;
		tx_e <= 1'b0;
		rd_chk(ADDR_LSR, 8'h00);
	endtask

	task automatic t_sources();
		tx_e <= 1'b1;
		host_u.wr(ADDR_ENABLE, 8'h02, 1'b1);
		chk({7'h00, irq}, 8'h01);
		rd_chk(ADDR_ISR, 8'hC2);
		rd_chk(ADDR_ISR, 8'hC1);
		host_u.wr(ADDR_ENABLE, 8'h00, 1'b1);
		count <= 5'h02;
		head_err <= 3'b001;
		host_u.wr(ADDR_ENABLE, 8'h06, 1'b1);
		rd_chk(ADDR_ISR, 8'hC6);
		head_err <= 3'b000;
		rd_chk(ADDR_ISR, 8'hC2);
		chk({7'h00, irq}, 8'h00);
		modem_input_status <= 8'h01;
		host_u.wr(ADDR_ENABLE, 8'h08, 1'b1);
		rd_chk(ADDR_ISR, 8'hC0);
		rd_chk(ADDR_MSR, 8'h01);
		chk(8'(n_msrd), 8'h01);
		modem_input_status <= 8'h00;
		rd_chk(ADDR_ISR, 8'hC1);
		// Xoff source and high modem bits live only with the feature bit
		host_u.wr(ADDR_ENABLE, 8'h20, 1'b1);
		xoff <= 1'b1;
		@(posedge mclk_i);
		xoff <= 1'b0;
		rd_chk(ADDR_ISR, 8'hD0);
		host_u.wr(ADDR_MCR, 8'hE3, 1'b1);
		chk(modem_output_control, 8'hE3);
		host_u.wr(ADDR_LCR, LCR_ENH_KEY, 1'b1);
		host_u.wr(ADDR_LSR, 8'h11, 1'b1);
		host_u.wr(ADDR_MSR, 8'h22, 1'b1);
		host_u.wr(ADDR_SPR, 8'h33, 1'b1);
		rd_chk(ADDR_LSR, 8'h11);
		rd_chk(ADDR_MSR, 8'h22);
		rd_chk(ADDR_SPR, 8'h33);
		host_u.wr(ADDR_ISR, 8'h00, 1'b1);
		chk(enhanced_feature_control, 8'h00);
		chk(ien, 8'h00);
		chk(modem_output_control, 8'h03);
		host_u.wr(ADDR_LCR, 8'h03, 1'b1);
		rd_chk(ADDR_SPR, 8'hA5);
		xoff <= 1'b1;
		@(posedge mclk_i);
		xoff <= 1'b0;
		rd_chk(ADDR_ISR, 8'hC1);
		chk({7'h00, irq}, 8'h00);
	endtask

	task automatic t_side_effects();
		rxd <= 8'h6D;
		count <= 5'h01;
		rd_chk(ADDR_DATA, 8'h6D);
		chk(8'(n_rxr), 8'h01);
		host_u.wr(ADDR_DATA, 8'h5C, 1'b1);
		chk(txd, 8'h5C);
		chk(8'(n_txw), 8'h01);
		rd_chk(ADDR_LCR, 8'h03);
		rd_chk(ADDR_LSR, 8'hE1);
		host_u.wr(ADDR_ISR, 8'h47, 1'b1);
		chk(qc, 8'h41);
		chk(8'(n_rxrst + n_txrst), 8'h02);
		rd_chk(ADDR_LSR, 8'h61);
	endtask

	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		mclk_i = 1'b0;
		reset_n_i = 1'b0;
		count = 5'h00;
		head_err = 3'b000;
		push = 1'b0;
		push_err = 1'b0;
		ovr = 1'b0;
		tx_e = 1'b0;
		sh_e = 1'b0;
		xoff = 1'b0;
		rxd = 8'h00;
		modem_input_status = 8'h00;
		n_fail = 0;
		comparisons = 0;
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		t_select();
		t_enhanced();
		t_rx_trigger();
		t_line_status();
		t_sources();
		t_side_effects();
		end_of_test();
	end
endmodule // tb
`default_nettype wire
